// File: rtl/cmc_pkg.sv
// Constants, register map and field layout of the comparator control logic
// Overview of operation
// - Enable bit low powers comparator down and forces the output bit low.
// - Polarity bit 0 passes raw result, 1 passes inverted result.
// - Output bit 4 is read-only, reads comparison result after polarity.
// - Hysteresis bit 0 disables hysteresis at 0, enables at 1; resets to 1.
// - Each change of the output bit sets the interrupt request flag.
// - Flag set with interrupt enabled raises the interrupt toward the vector.
// - In sleep or idle with comparator on, a flag-setting change wakes device.
// - Flag already set before sleep suppresses wake-up from later changes.
// - Enabled comparator keeps running and tracking during sleep or idle.
// - Selecting comparator input pin functions disconnects their pull-ups.
// - Output can be driven onto a shared pin when that function is selected.
// - Bits 7 and 3 to 1 read zero; writes to them do nothing.
package cmc_pkg;

	// ******************************************************************
	// Register byte offsets
	// ******************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_MASK    = 8'h08;
	localparam logic [7:0] OFS_FORCE   = 8'h0C;

	// ******************************************************************
	// Control register fields, and flag bit of status, mask and force
	// ******************************************************************
	localparam int BIT_ON     = 6;
	localparam int BIT_INVERT = 5;
	localparam int BIT_RESULT = 4;
	localparam int BIT_HYST   = 0;
	localparam int BIT_FLAG   = 0;

	localparam logic RST_ON     = 1'b0;
	localparam logic RST_INVERT = 1'b0;
	localparam logic RST_HYST   = 1'b1;
	localparam logic RST_FLAG   = 1'b0;
	localparam logic RST_MASK   = 1'b0;

	// ******************************************************************
	// Bus answers
	// ******************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

endpackage

// File: rtl/cmc_result_if.sv
// Carrier between the control logic and the result tracker
`timescale 1ns/10ps
`default_nettype none
interface cmc_result_if;
	logic on;
	logic invert;
	logic result;
	logic changed;

	modport ctrl (output on, output invert, input result, input changed);
	modport trk  (input on, input invert, output result, output changed);
endinterface
`default_nettype wire

// File: rtl/cmc_tracker.sv
// Synchroniser, polarity and change detector for the comparator result
`timescale 1ns/10ps
`default_nettype none
module cmc_tracker (
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire logic     cmp_raw,
	cmc_result_if.trk     res
);
	logic meta_ff;
	logic sync_ff;
	logic result_ff;
	logic changed_ff;
	logic nxt_result;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= 1'h0;
			sync_ff <= 1'h0;
		end else begin
			meta_ff <= cmp_raw;
			sync_ff <= meta_ff;
		end
	end

	// Disabled comparator holds the result low, polarity applied after sync
	assign nxt_result = res.on & (sync_ff ^ res.invert);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_ff  <= 1'h0;
			changed_ff <= 1'h0;
		end else begin
			result_ff  <= nxt_result;
			changed_ff <= nxt_result ^ result_ff;
		end
	end

	assign res.result  = result_ff;
	assign res.changed = changed_ff;
endmodule
`default_nettype wire

// File: rtl/cmc_ctrl.sv
// Comparator control logic with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module cmc_ctrl (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cmp_raw,
	input  wire logic        low_power_mode,
	input  wire logic        input_pins_select,
	input  wire logic        output_pin_select,
	output logic             comparator_power,
	output logic             hysteresis_enable,
	output logic             pullup_disconnect,
	output logic             cmp_pin_out,
	output logic             cmp_pin_oe,
	output logic             irq,
	output logic             wake
);

	// ******************************************************************
	// Result tracker
	// ******************************************************************
	cmc_result_if res ();

	cmc_tracker cmc_tracker_i (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cmp_raw (cmp_raw),
		.res     (res)
	);

	// ******************************************************************
	// Register state
	// ******************************************************************
	logic        on_ff;
	logic        invert_ff;
	logic        hyst_ff;
	logic        flag_ff;
	logic        mask_ff;
	logic        irq_ff;
	logic        wake_ff;
	logic        power_ff;
	logic        pullup_off_ff;
	logic        pin_out_ff;
	logic        pin_oe_ff;

	// ******************************************************************
	// Address decode shared by both channels
	// ******************************************************************
	function automatic logic reg_hit(input logic [7:0] addr);
		return (addr == cmc_pkg::OFS_CONTROL) | (addr == cmc_pkg::OFS_STATUS) |
		       (addr == cmc_pkg::OFS_MASK) | (addr == cmc_pkg::OFS_FORCE);
	endfunction

	// ******************************************************************
	// Write channel
	// ******************************************************************
	logic        aw_full_ff;
	logic [7:0]  aw_addr_ff;
	logic        w_full_ff;
	logic [31:0] w_data_ff;
	logic        w_lane0_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        awready_ff;
	logic        wready_ff;

	wire         aw_take = s_axi_awvalid & awready_ff;
	wire         w_take  = s_axi_wvalid & wready_ff;
	wire         do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
	// Next channel state, shared by the registered readies
	wire         nxt_aw_full = aw_take | (aw_full_ff & ~do_write);
	wire         nxt_w_full  = w_take | (w_full_ff & ~do_write);
	wire         nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready);
	wire         wr_lane = w_lane0_ff;
	wire         wr_ctrl = do_write & wr_lane & (aw_addr_ff == cmc_pkg::OFS_CONTROL);
	wire         wr_stat = do_write & wr_lane & (aw_addr_ff == cmc_pkg::OFS_STATUS);
	wire         wr_mask = do_write & wr_lane & (aw_addr_ff == cmc_pkg::OFS_MASK);
	wire         wr_force = do_write & wr_lane & (aw_addr_ff == cmc_pkg::OFS_FORCE);
	wire         wr_hit = reg_hit(aw_addr_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'h0;
			aw_addr_ff <= 8'h00;
		end else if (aw_take) begin
			aw_full_ff <= 1'h1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full_ff <= 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_ff  <= 1'h0;
			w_data_ff  <= cmc_pkg::DATA_ZERO;
			w_lane0_ff <= 1'h0;
		end else if (w_take) begin
			w_full_ff  <= 1'h1;
			w_data_ff  <= s_axi_wdata;
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_full_ff <= 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'h0;
			bresp_ff  <= cmc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'h1;
			bresp_ff  <= wr_hit ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'h0;
		end
	end

	// ******************************************************************
	// Write readies
	// ******************************************************************
	// Registered so the ports come straight from flip-flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'h1;
			wready_ff  <= 1'h1;
		end else begin
			awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
		end
	end

	// ******************************************************************
	// Control register, unimplemented bits never stored
	// ******************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_ff     <= cmc_pkg::RST_ON;
			invert_ff <= cmc_pkg::RST_INVERT;
			hyst_ff   <= cmc_pkg::RST_HYST;
		end else if (wr_ctrl) begin
			on_ff     <= w_data_ff[cmc_pkg::BIT_ON];
			invert_ff <= w_data_ff[cmc_pkg::BIT_INVERT];
			hyst_ff   <= w_data_ff[cmc_pkg::BIT_HYST];
		end
	end

	assign res.on     = on_ff;
	assign res.invert = invert_ff;

	// ******************************************************************
	// Interrupt flag, mask and wake-up
	// ******************************************************************
	wire flag_set = res.changed | (wr_force & w_data_ff[cmc_pkg::BIT_FLAG]);
	wire flag_clr = wr_stat & w_data_ff[cmc_pkg::BIT_FLAG];
	wire nxt_flag = flag_set | (flag_ff & ~flag_clr);
	wire nxt_wake = low_power_mode & on_ff & res.changed & ~flag_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_ff <= cmc_pkg::RST_FLAG;
			mask_ff <= cmc_pkg::RST_MASK;
		end else begin
			flag_ff <= nxt_flag;
			if (wr_mask) begin
				mask_ff <= w_data_ff[cmc_pkg::BIT_FLAG];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff  <= 1'h0;
			wake_ff <= 1'h0;
		end else begin
			irq_ff  <= flag_ff & mask_ff;
			wake_ff <= nxt_wake;
		end
	end

	// ******************************************************************
	// Analog and pin controls
	// ******************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_ff      <= cmc_pkg::RST_ON;
			pullup_off_ff <= 1'h0;
			pin_out_ff    <= 1'h0;
			pin_oe_ff     <= 1'h0;
		end else begin
			power_ff      <= on_ff;
			pullup_off_ff <= input_pins_select;
			pin_out_ff    <= res.result;
			pin_oe_ff     <= output_pin_select;
		end
	end

	// ******************************************************************
	// Read channel
	// ******************************************************************
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        arready_ff;

	wire ar_take    = s_axi_arvalid & arready_ff;
	wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

	// Read data captured at the address handshake

	always_comb begin
		rd_word = cmc_pkg::DATA_ZERO;
		rd_hit  = reg_hit(s_axi_araddr);
		unique case (s_axi_araddr)
			cmc_pkg::OFS_CONTROL: begin
				rd_word[cmc_pkg::BIT_ON]     = on_ff;
				rd_word[cmc_pkg::BIT_INVERT] = invert_ff;
				rd_word[cmc_pkg::BIT_RESULT] = res.result;
				rd_word[cmc_pkg::BIT_HYST]   = hyst_ff;
			end
			cmc_pkg::OFS_STATUS: begin
				rd_word[cmc_pkg::BIT_FLAG] = flag_ff;
			end
			cmc_pkg::OFS_MASK: begin
				rd_word[cmc_pkg::BIT_FLAG] = mask_ff;
			end
			cmc_pkg::OFS_FORCE: begin
				rd_word = cmc_pkg::DATA_ZERO;
			end
			default: begin
				rd_word = cmc_pkg::DATA_ZERO;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'h0;
			rdata_ff  <= cmc_pkg::DATA_ZERO;
			rresp_ff  <= cmc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'h1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_hit ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'h0;
		end
	end

	// Read ready is a registered inverse of the next read state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'h1;
		end else begin
			arready_ff <= ~nxt_rvalid;
		end
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	assign s_axi_awready     = awready_ff;
	assign s_axi_wready      = wready_ff;
	assign s_axi_bvalid      = bvalid_ff;
	assign s_axi_bresp       = bresp_ff;
	assign s_axi_arready     = arready_ff;
	assign s_axi_rvalid      = rvalid_ff;
	assign s_axi_rdata       = rdata_ff;
	assign s_axi_rresp       = rresp_ff;
	assign comparator_power  = power_ff;
	assign hysteresis_enable = hyst_ff;
	assign pullup_disconnect = pullup_off_ff;
	assign cmp_pin_out       = pin_out_ff;
	assign cmp_pin_oe        = pin_oe_ff;
	assign irq               = irq_ff;
	assign wake              = wake_ff;

endmodule
`default_nettype wire

// File: tb/cmc_cmp_model.sv
// Behavioural analog comparator core
`timescale 1ns/10ps
`default_nettype none
module cmc_cmp_model (
	input  wire logic [7:0] pos,
	input  wire logic [7:0] neg,
	input  wire logic       power,
	output logic            cmp_raw
);
	logic noise = 1'h0;
	// Unpowered core output means nothing, so it chatters
	always #13 noise = ~noise;
	assign cmp_raw = power ? (pos > neg) : noise;
endmodule
`default_nettype wire

// File: tb/cmc_ctrl_chk.sv
// Port assertions of the comparator control logic
`timescale 1ns/10ps
`default_nettype none
module cmc_ctrl_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        low_power_mode,
	input wire logic        input_pins_select,
	input wire logic        output_pin_select,
	input wire logic        comparator_power,
	input wire logic        hysteresis_enable,
	input wire logic        pullup_disconnect,
	input wire logic        cmp_pin_out,
	input wire logic        cmp_pin_oe,
	input wire logic        irq,
	input wire logic        wake
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	pullup_cut_a: assert property ($past(aresetn) |->
		pullup_disconnect == $past(input_pins_select)) else $error("pull-up cut lag");
	pin_oe_a: assert property ($past(aresetn) |->
		cmp_pin_oe == $past(output_pin_select)) else $error("pin enable lag");
	off_low_a: assert property (!comparator_power [*3] |-> !cmp_pin_out)
		else $error("output high while off");
	wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
	wake_cause_a: assert property (wake |->
		$past(low_power_mode) && $past(comparator_power)) else $error("wake without sleep");
	hyst_reset_a: assert property ($rose(aresetn) |-> hysteresis_enable)
		else $error("hysteresis reset");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	cover property (wake);
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
`default_nettype wire

// File: tb/cmc_ctrl_bench.sv
// Self-checking bench of the comparator control logic
`timescale 1ns/10ps
`default_nettype none
module cmc_ctrl_bench;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, pos = 8'h10, neg = 8'h20;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, q, x, seed = 32'h0001_5A9D;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0, cmp_raw;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        low_power_mode = '0, input_pins_select = '0, output_pin_select = '0;
	logic        comparator_power, hysteresis_enable, pullup_disconnect;
	logic        cmp_pin_out, cmp_pin_oe, irq, wake;
	int          n_mismatch = 0, cmp_count = 0, n_wake = 0, w;

	cmc_ctrl cmc_ctrl_i (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.s_axi_awaddr      (s_axi_awaddr),
		.s_axi_awvalid     (s_axi_awvalid),
		.s_axi_awready     (s_axi_awready),
		.s_axi_wdata       (s_axi_wdata),
		.s_axi_wstrb       (s_axi_wstrb),
		.s_axi_wvalid      (s_axi_wvalid),
		.s_axi_wready      (s_axi_wready),
		.s_axi_bresp       (s_axi_bresp),
		.s_axi_bvalid      (s_axi_bvalid),
		.s_axi_bready      (s_axi_bready),
		.s_axi_araddr      (s_axi_araddr),
		.s_axi_arvalid     (s_axi_arvalid),
		.s_axi_arready     (s_axi_arready),
		.s_axi_rdata       (s_axi_rdata),
		.s_axi_rresp       (s_axi_rresp),
		.s_axi_rvalid      (s_axi_rvalid),
		.s_axi_rready      (s_axi_rready),
		.cmp_raw           (cmp_raw),
		.low_power_mode    (low_power_mode),
		.input_pins_select (input_pins_select),
		.output_pin_select (output_pin_select),
		.comparator_power  (comparator_power),
		.hysteresis_enable (hysteresis_enable),
		.pullup_disconnect (pullup_disconnect),
		.cmp_pin_out       (cmp_pin_out),
		.cmp_pin_oe        (cmp_pin_oe),
		.irq               (irq),
		.wake              (wake)
	);
	cmc_cmp_model cmc_cmp_model_i (
		.pos     (pos),
		.neg     (neg),
		.power   (comparator_power),
		.cmp_raw (cmp_raw)
	);

	always #20 aclk = ~aclk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Control readback: writable bits kept, result gated by enable and polarity
	function automatic logic [31:0] ctl_exp(logic [31:0] v, logic raw);
		return (v & 32'h0000_0061) | {27'h0, v[6] & (raw ^ v[5]), 4'h0};
	endfunction

	always @(posedge aclk) begin
		x = rnd();
		input_pins_select <= x[0];
		output_pin_select <= x[1];
		if (wake === 1'h1) n_wake <= n_wake + 1;
	end

	task automatic conclude();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 40) begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// Response ready comes late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n = 0;
		bit done = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!done) begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bready && s_axi_bvalid) begin
				chk("bresp", s_axi_bresp, er);
				done = 1;
				s_axi_bready <= 1'h0;
			end else if (n > 3) s_axi_bready <= 1'h1;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n = 0;
		bit done = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		while (!done) begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rready && s_axi_rvalid) begin
				v = s_axi_rdata;
				rr = s_axi_rresp;
				done = 1;
				s_axi_rready <= 1'h0;
			end else if (n > 2) s_axi_rready <= 1'h1;
		end
	endtask

	initial begin
		wt(5);
		aresetn <= 1'h1;
		wt(1);
		rd(cmc_pkg::OFS_CONTROL, q, r);
		chk("ctl_reset", q, 32'h0000_0001);
		wr(8'h10, 32'hFFFF_FFFF, cmc_pkg::RESP_SLVERR);
		rd(8'h10, q, r);
		chk("unmapped", {r, q[29:0]}, {cmc_pkg::RESP_SLVERR, 30'h0});
		for (int i = 0; i < 16; i++) begin
			d = rnd();
			pos <= d[15:8];
			neg <= d[23:16];
			wr(cmc_pkg::OFS_CONTROL, d, cmc_pkg::RESP_OKAY);
			wt(6);
			rd(cmc_pkg::OFS_CONTROL, q, r);
			chk("ctl_read", q, ctl_exp(d, pos > neg));
			chk("pin_out", cmp_pin_out, ctl_exp(d, pos > neg) >> 4 & 32'h1);
			chk("hyst_pin", hysteresis_enable, d[0]);
			chk("power", comparator_power, d[6]);
		end
		neg <= 8'h80;
		pos <= 8'h00;
		wr(cmc_pkg::OFS_CONTROL, 32'h41, cmc_pkg::RESP_OKAY);
		wt(8);
		wr(cmc_pkg::OFS_MASK, 32'h1, cmc_pkg::RESP_OKAY);
		wr(cmc_pkg::OFS_STATUS, 32'h1, cmc_pkg::RESP_OKAY);
		wt(2);
		chk("irq_idle", irq, 32'h0);
		pos <= 8'hFF;
		wt(8);
		chk("irq_set", irq, 32'h1);
		wt(20);
		rd(cmc_pkg::OFS_STATUS, q, r);
		chk("flag_held", q, 32'h1);
		wr(cmc_pkg::OFS_STATUS, 32'h1, cmc_pkg::RESP_OKAY);
		wt(3);
		chk("irq_clear", irq, 32'h0);
		wr(cmc_pkg::OFS_MASK, 32'h0, cmc_pkg::RESP_OKAY);
		pos <= 8'h00;
		wt(8);
		chk("irq_masked", irq, 32'h0);
		rd(cmc_pkg::OFS_STATUS, q, r);
		chk("flag_masked", q, 32'h1);
		wr(cmc_pkg::OFS_STATUS, 32'h1, cmc_pkg::RESP_OKAY);
		low_power_mode <= 1'h1;
		w = n_wake;
		pos <= 8'hFF;
		wt(8);
		chk("wake_one", n_wake - w, 32'h1);
		pos <= 8'h00;
		wt(8);
		chk("wake_held", n_wake - w, 32'h1);
		rd(cmc_pkg::OFS_CONTROL, q, r);
		chk("sleep_track", q, 32'h41);
		s_axi_wstrb <= 4'hE;
		wr(cmc_pkg::OFS_CONTROL, 32'h0, cmc_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(cmc_pkg::OFS_CONTROL, q, r);
		chk("lane_off", q, 32'h41);
		wr(cmc_pkg::OFS_STATUS, 32'h1, cmc_pkg::RESP_OKAY);
		wr(cmc_pkg::OFS_FORCE, 32'h1, cmc_pkg::RESP_OKAY);
		pos <= 8'hFF;
		wt(8);
		chk("wake_forced", n_wake - w, 32'h1);
		aresetn <= 1'h0;
		wt(2);
		aresetn <= 1'h1;
		wt(1);
		rd(cmc_pkg::OFS_CONTROL, q, r);
		chk("ctl_rereset", q, 32'h0000_0001);
		conclude();
	end
endmodule

bind cmc_ctrl cmc_ctrl_chk cmc_ctrl_chk_i (
	.aclk              (aclk),
	.aresetn           (aresetn),
	.s_axi_bresp       (s_axi_bresp),
	.s_axi_bvalid      (s_axi_bvalid),
	.s_axi_bready      (s_axi_bready),
	.s_axi_rdata       (s_axi_rdata),
	.s_axi_rvalid      (s_axi_rvalid),
	.s_axi_rready      (s_axi_rready),
	.low_power_mode    (low_power_mode),
	.input_pins_select (input_pins_select),
	.output_pin_select (output_pin_select),
	.comparator_power  (comparator_power),
	.hysteresis_enable (hysteresis_enable),
	.pullup_disconnect (pullup_disconnect),
	.cmp_pin_out       (cmp_pin_out),
	.cmp_pin_oe        (cmp_pin_oe),
	.irq               (irq),
	.wake              (wake)
);
`default_nettype wire
